// [core/eepw_host.v]
// host controller for a page-write memory with write lock
`timescale 1ns/100ps
`include "eepw_defines.vh"

module eepw_host
#(
  parameter [31:0] PON_CYC  = `EEPW_PON_CYC,
  parameter [31:0] WC_CYC   = `EEPW_WC_CYC,
  parameter [31:0] BLC_CYC  = `EEPW_BLC_CYC,
  parameter [18:0] CMD_A0   = 19'h05555,
  parameter [18:0] CMD_A1   = 19'h02aaa,
  parameter [18:0] CMD_A2   = 19'h05555,
  parameter [7:0]  CMD_D0   = 8'haa,
  parameter [7:0]  CMD_D1   = 8'h55,
  parameter [7:0]  ENA_D2   = 8'ha0,
  parameter [7:0]  DIS_D2   = 8'h20
)
(
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_i,
  // user command port
  input  wire        cmd_valid_i,
  input  wire [1:0]  cmd_op_i,
  input  wire [18:0] cmd_addr_i,
  input  wire [7:0]  cmd_wdata_i,
  input  wire        cmd_last_i,
  input  wire        use_lock_i,
  input  wire        det_mode_i,
  output reg         cmd_ready_o,
  output reg         rsp_valid_o,
  output reg  [7:0]  rsp_rdata_o,
  output reg         busy_o,
  output reg         timeout_o,
  // memory pins
  output wire [18:0] addr_lines_o,
  output wire        chip_sel_n_o,
  output wire        out_en_n_o,
  output wire        wr_strobe_n_o,
  output wire [7:0]  data_pins_o,
  output wire        data_pins_oe_n_o,
  input  wire [7:0]  data_pins_i
);

  localparam ST_PON   = 3'd0;
  localparam ST_IDLE  = 3'd1;
  localparam ST_PFX   = 3'd2;
  localparam ST_LOAD  = 3'd3;
  localparam ST_POLL  = 3'd4;
  localparam ST_READ  = 3'd5;

  reg  [2:0]  state_reg;
  reg  [31:0] tmr_reg;
  reg  [31:0] wc_reg;
  reg  [1:0]  pfx_idx_reg;
  reg  [1:0]  pend_op_reg;
  reg  [18:0] last_addr_reg;
  reg  [7:0]  last_data_reg;
  reg  [11:0] page_reg;
  reg         prev_tgl_reg;
  reg         have_tgl_reg;
  reg         last_reg;
  reg         go_reg;
  reg         wr_reg;
  reg  [18:0] a_reg;
  reg  [7:0]  d_reg;
  wire        done;
  wire [7:0]  rdata;
  reg  [7:0]  pfx_d;
  reg  [18:0] pfx_a;
  reg  [6:0]  usr_lo_reg;
  reg  [7:0]  usr_d_reg;
  // command bytes are never stored, so a lock change is only seen by the toggle bit
  wire        tgl_det = (det_mode_i == `EEPW_DET_TOGGLE) || (pend_op_reg != `EEPW_CMD_WRITE);

  // ============================================================
  // pin sequencer
  eepw_strobe u_strobe
  (
    .sys_clk_i        (sys_clk_i),
    .rst_i            (rst_i),
    .go_i             (go_reg),
    .wr_i             (wr_reg),
    .addr_i           (a_reg),
    .wdata_i          (d_reg),
    .done_o           (done),
    .rdata_o          (rdata),
    .addr_lines_o     (addr_lines_o),
    .chip_sel_n_o     (chip_sel_n_o),
    .out_en_n_o       (out_en_n_o),
    .wr_strobe_n_o    (wr_strobe_n_o),
    .data_pins_o      (data_pins_o),
    .data_pins_oe_n_o (data_pins_oe_n_o),
    .data_pins_i      (data_pins_i)
  );

  // ============================================================
  // command prefix table
  always @*
  begin
    pfx_a = CMD_A0;
    pfx_d = CMD_D0;
    case (pfx_idx_reg)
      2'd0:
      begin
        pfx_a = CMD_A0;
        pfx_d = CMD_D0;
      end
      2'd1:
      begin
        pfx_a = CMD_A1;
        pfx_d = CMD_D1;
      end
      default:
      begin
        pfx_a = CMD_A2;
        pfx_d = (pend_op_reg == `EEPW_CMD_LOCK_OFF) ? DIS_D2 : ENA_D2;
      end
    endcase
  end

  // ============================================================
  // main sequencer
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg     <= ST_PON;
      tmr_reg       <= 32'h00000000;
      wc_reg        <= 32'h00000000;
      pfx_idx_reg   <= 2'd0;
      pend_op_reg   <= 2'd0;
      last_addr_reg <= 19'h00000;
      last_data_reg <= 8'h00;
      page_reg      <= 12'h000;
      prev_tgl_reg  <= 1'b0;
      have_tgl_reg  <= 1'b0;
      last_reg      <= 1'b0;
      go_reg        <= 1'b0;
      wr_reg        <= 1'b0;
      a_reg         <= 19'h00000;
      d_reg         <= 8'h00;
      usr_lo_reg    <= 7'h00;
      usr_d_reg     <= 8'h00;
      cmd_ready_o   <= 1'b0;
      rsp_valid_o   <= 1'b0;
      rsp_rdata_o   <= 8'h00;
      busy_o        <= 1'b1;
      timeout_o     <= 1'b0;
    end
    else
    begin
      go_reg      <= 1'b0;
      rsp_valid_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      case (state_reg)
        ST_PON:
        begin
          // wait out the power-on write block
          if (tmr_reg + 32'h00000001 >= PON_CYC)
          begin
            state_reg   <= ST_IDLE;
            busy_o      <= 1'b0;
            cmd_ready_o <= 1'b1;
          end
          else
            tmr_reg <= tmr_reg + 32'h00000001;
        end
        ST_IDLE:
        begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o)
          begin
            cmd_ready_o <= 1'b0;
            pend_op_reg <= cmd_op_i;
            // the prefix reuses a_reg and d_reg; keep the user byte aside
            usr_lo_reg  <= cmd_addr_i[6:0];
            usr_d_reg   <= cmd_wdata_i;
            last_reg    <= cmd_last_i;
            a_reg       <= cmd_addr_i;
            d_reg       <= cmd_wdata_i;
            pfx_idx_reg <= 2'd0;
            if (cmd_op_i == `EEPW_CMD_READ)
            begin
              wr_reg    <= 1'b0;
              go_reg    <= 1'b1;
              state_reg <= ST_READ;
            end
            else
            begin
              busy_o <= 1'b1;
              page_reg <= cmd_addr_i[18:7];
              // lock commands and locked writes carry the prefix
              state_reg <= (cmd_op_i != `EEPW_CMD_WRITE || use_lock_i) ? ST_PFX : ST_LOAD;
              tmr_reg <= 32'h00000000;
            end
          end
        end
        ST_PFX:
        begin
          // prefix bytes sent as page loads, same timing
          if (!go_reg && tmr_reg == 32'h00000000)
          begin
            wr_reg  <= 1'b1;
            go_reg  <= 1'b1;
            tmr_reg <= 32'h00000001;
          end
          else if (done)
          begin
            tmr_reg <= 32'h00000000;
            if (pfx_idx_reg == 2'd2)
            begin
              if (pend_op_reg == `EEPW_CMD_WRITE)
              begin
                a_reg     <= {page_reg, usr_lo_reg};
                d_reg     <= usr_d_reg;
                state_reg <= ST_LOAD;
              end
              else
              begin
                // lock change lands after program time
                last_addr_reg <= pfx_a;
                last_data_reg <= pfx_d;
                wc_reg        <= 32'h00000000;
                have_tgl_reg  <= 1'b0;
                state_reg     <= ST_POLL;
              end
            end
            else
              pfx_idx_reg <= pfx_idx_reg + 2'd1;
          end
        end
        ST_LOAD:
        begin
          if (!go_reg && tmr_reg == 32'h00000000)
          begin
            // keep the page address for the whole load
            a_reg   <= {page_reg, a_reg[6:0]};
            wr_reg  <= 1'b1;
            go_reg  <= 1'b1;
            tmr_reg <= 32'h00000001;
          end
          else if (done)
          begin
            last_addr_reg <= {page_reg, a_reg[6:0]};
            last_data_reg <= d_reg;
            tmr_reg       <= 32'h00000002;
            wc_reg        <= 32'h00000000;
            if (last_reg)
            begin
              have_tgl_reg <= 1'b0;
              state_reg    <= ST_POLL;
            end
          end
          else if (tmr_reg >= 32'h00000002)
          begin
            // next byte must arrive inside the load window
            tmr_reg     <= tmr_reg + 32'h00000001;
            cmd_ready_o <= 1'b1;
            if (cmd_valid_i && cmd_ready_o && cmd_op_i == `EEPW_CMD_WRITE)
            begin
              cmd_ready_o <= 1'b0;
              a_reg       <= cmd_addr_i;
              d_reg       <= cmd_wdata_i;
              last_reg    <= cmd_last_i;
              tmr_reg     <= 32'h00000000;
            end
            else if (tmr_reg >= BLC_CYC)
            begin
              cmd_ready_o  <= 1'b0;
              timeout_o    <= 1'b1;
              have_tgl_reg <= 1'b0;
              state_reg    <= ST_POLL;
            end
          end
        end
        ST_POLL:
        begin
          // no new load until the device reports done or program time runs out
          if (wc_reg < WC_CYC)
            wc_reg <= wc_reg + 32'h00000001;
          if (!go_reg && !done && tmr_reg != 32'h00000001)
          begin
            wr_reg  <= 1'b0;
            a_reg   <= last_addr_reg;
            go_reg  <= 1'b1;
            tmr_reg <= 32'h00000001;
          end
          else if (done)
          begin
            tmr_reg      <= 32'h00000000;
            have_tgl_reg <= 1'b1;
            prev_tgl_reg <= rdata[`EEPW_TOGGLE_BIT];
            // poll: bit 7 true again; toggle: bit 6 stopped flipping
            if ((!tgl_det &&
                 rdata[`EEPW_POLL_BIT] == last_data_reg[`EEPW_POLL_BIT]) ||
                (tgl_det && have_tgl_reg &&
                 rdata[`EEPW_TOGGLE_BIT] == prev_tgl_reg))
            begin
              busy_o    <= 1'b0;
              timeout_o <= 1'b0;
              state_reg <= ST_IDLE;
            end
            else if (wc_reg >= WC_CYC)
            begin
              // device stuck past program time; give up, flag it
              busy_o    <= 1'b0;
              timeout_o <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_READ:
        begin
          // plain read, outputs enabled only during the strobe
          if (done)
          begin
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= rdata;
            state_reg   <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
      if (state_reg == ST_PFX && !(done && pfx_idx_reg == 2'd2) && !go_reg && tmr_reg == 32'h00000000)
      begin
        a_reg <= pfx_a;
        d_reg <= pfx_d;
      end
    end
  end

endmodule

// [pkg/eepw_defines.vh]
// constants for the page-write memory host controller
`ifndef EEPW_DEFINES_VH
`define EEPW_DEFINES_VH

// pin timing, ns at a 10 ns clock
`define EEPW_CLK_NS          10
`define EEPW_WP_NS           100
`define EEPW_WP_CYC          ((`EEPW_WP_NS + `EEPW_CLK_NS - 1) / `EEPW_CLK_NS)
`define EEPW_WPH_NS          50
`define EEPW_WPH_CYC         ((`EEPW_WPH_NS + `EEPW_CLK_NS - 1) / `EEPW_CLK_NS)
`define EEPW_ACC_NS          300
`define EEPW_ACC_CYC         ((`EEPW_ACC_NS + `EEPW_CLK_NS - 1) / `EEPW_CLK_NS)
`define EEPW_OEHP_NS         150
`define EEPW_OEHP_CYC        ((`EEPW_OEHP_NS + `EEPW_CLK_NS - 1) / `EEPW_CLK_NS)
// byte load window, us; longest time rounds down
`define EEPW_BLC_US          150
`define EEPW_BLC_CYC         (`EEPW_BLC_US * 1000 / `EEPW_CLK_NS)
// program time, ms
`define EEPW_WC_MS           10
`define EEPW_WC_CYC          (`EEPW_WC_MS * 1000000 / `EEPW_CLK_NS)
// power-on delay, ms
`define EEPW_PON_MS          5
`define EEPW_PON_CYC         (`EEPW_PON_MS * 1000000 / `EEPW_CLK_NS)

// widths
`define EEPW_AW              19
`define EEPW_PAGE_BYTES      128
`define EEPW_POLL_BIT        7
`define EEPW_TOGGLE_BIT      6

// host command codes
`define EEPW_CMD_READ        2'h0
`define EEPW_CMD_WRITE       2'h1
`define EEPW_CMD_LOCK_ON     2'h2
`define EEPW_CMD_LOCK_OFF    2'h3

// end-of-write detection methods
`define EEPW_DET_POLL        1'b0
`define EEPW_DET_TOGGLE      1'b1

`endif

// [core/eepw_strobe.v]
// one bus cycle on the memory pins: read or write strobe
`timescale 1ns/100ps
`include "eepw_defines.vh"

module eepw_strobe
(
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_i,
  // request
  input  wire        go_i,
  input  wire        wr_i,
  input  wire [18:0] addr_i,
  input  wire [7:0]  wdata_i,
  output reg         done_o,
  output reg  [7:0]  rdata_o,
  // memory pins
  output reg  [18:0] addr_lines_o,
  output reg         chip_sel_n_o,
  output reg         out_en_n_o,
  output reg         wr_strobe_n_o,
  output reg  [7:0]  data_pins_o,
  output reg         data_pins_oe_n_o,
  input  wire [7:0]  data_pins_i
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_LOW   = 2'd1;
  localparam ST_HIGH  = 2'd2;

  // strobe timing counts, cut to the counter width below
  localparam [31:0] WP_CYC   = `EEPW_WP_CYC;
  localparam [31:0] WPH_CYC  = `EEPW_WPH_CYC;
  localparam [31:0] ACC_CYC  = `EEPW_ACC_CYC;
  localparam [31:0] OEHP_CYC = `EEPW_OEHP_CYC;

  reg [1:0]  state_reg;
  reg        wr_reg;
  reg [15:0] cnt_reg;

  // ============================================================
  // strobe sequencer
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg        <= ST_IDLE;
      wr_reg           <= 1'b0;
      cnt_reg          <= 16'h0000;
      done_o           <= 1'b0;
      rdata_o          <= 8'h00;
      addr_lines_o     <= 19'h00000;
      chip_sel_n_o     <= 1'b1;
      out_en_n_o       <= 1'b1;
      wr_strobe_n_o    <= 1'b1;
      data_pins_o      <= 8'h00;
      data_pins_oe_n_o <= 1'b1;
    end
    else
    begin
      done_o <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (go_i)
          begin
            wr_reg       <= wr_i;
            addr_lines_o <= addr_i;
            data_pins_o  <= wdata_i;
            chip_sel_n_o <= 1'b0;
            if (wr_i)
            begin
              // output enable stays high through the write pulse
              out_en_n_o       <= 1'b1;
              wr_strobe_n_o    <= 1'b0;
              data_pins_oe_n_o <= 1'b0;
              // pulse well above the noise filter width
              cnt_reg          <= WP_CYC[15:0];
            end
            else
            begin
              out_en_n_o       <= 1'b0;
              wr_strobe_n_o    <= 1'b1;
              data_pins_oe_n_o <= 1'b1;
              cnt_reg          <= ACC_CYC[15:0];
            end
            state_reg <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          if (cnt_reg > 16'h0001)
            cnt_reg <= cnt_reg - 16'h0001;
          else
          begin
            // rising strobe ends the write while data still held
            if (!wr_reg)
              rdata_o <= data_pins_i;
            wr_strobe_n_o <= 1'b1;
            out_en_n_o    <= 1'b1;
            chip_sel_n_o  <= 1'b1;
            cnt_reg       <= wr_reg ? WPH_CYC[15:0] : OEHP_CYC[15:0];
            state_reg     <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          data_pins_oe_n_o <= 1'b1;
          if (cnt_reg > 16'h0001)
            cnt_reg <= cnt_reg - 16'h0001;
          else
          begin
            done_o    <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// [sim/eepw_host_assertions.sv]
// pin-level assertions on the host controller
`timescale 1ns/100ps
module eepw_host_chk
#(
  parameter [31:0] PON_CYC = 32'd20
)
(
  input wire        sys_clk_i,
  input wire        rst_i,
  input wire        rsp_valid_o,
  input wire        busy_o,
  input wire        timeout_o,
  input wire [18:0] addr_lines_o,
  input wire        chip_sel_n_o,
  input wire        out_en_n_o,
  input wire        wr_strobe_n_o,
  input wire [7:0]  data_pins_o,
  input wire        data_pins_oe_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ===========================================================
  // cycles since reset release, saturating
  reg [31:0] up_reg;
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      up_reg <= 32'h0;
    else if (up_reg < PON_CYC)
      up_reg <= up_reg + 32'h1;
  a_wr_oe_high:
    assert property (!wr_strobe_n_o |-> out_en_n_o && !chip_sel_n_o) else $error("write strobe while reading");
  a_no_contend:
    assert property (!data_pins_oe_n_o |-> out_en_n_o) else $error("host drives data while reading");
  a_wr_width:
    assert property ($fell(wr_strobe_n_o) |-> (!wr_strobe_n_o)[*8]) else $error("write pulse too short");
  a_wr_hold:
    assert property (!wr_strobe_n_o && !$past(wr_strobe_n_o) |-> $stable(addr_lines_o) && $stable(data_pins_o)
      && !data_pins_oe_n_o) else $error("address or data moved in write pulse");
  a_rd_strobe:
    assert property ($fell(out_en_n_o) |-> (wr_strobe_n_o && !chip_sel_n_o && data_pins_oe_n_o)[*8])
      else $error("read strobe malformed");
  a_rd_addr:
    assert property (!out_en_n_o && !$past(out_en_n_o) |-> $stable(addr_lines_o)) else $error("address moved in read");
  a_rd_recover:
    assert property ($rose(out_en_n_o) |-> out_en_n_o[*8]) else $error("read recovery too short");
  a_power_wait:
    assert property (up_reg < PON_CYC |-> wr_strobe_n_o) else $error("write before power-on delay");
  a_busy_write:
    assert property ($fell(wr_strobe_n_o) |-> busy_o) else $error("write pulse while not busy");
  c_write: cover property ($fell(wr_strobe_n_o));
  c_read: cover property (rsp_valid_o);
  c_tmo: cover property ($rose(timeout_o));
endmodule
bind eepw_host eepw_host_chk #(.PON_CYC(PON_CYC)) u_chk (.*);

// [sim/eepw_dev_model.sv]
// behavioural model of the page-write memory behind the pins
`timescale 1ns/100ps
module eepw_dev_model
#(
  parameter        BLC_CYC = 100,
  parameter        PON_CYC = 15,
  parameter [18:0] CMD_A0  = 19'h05555,
  parameter [18:0] CMD_A1  = 19'h02aaa,
  parameter [18:0] CMD_A2  = 19'h05555,
  parameter [7:0]  CMD_D0  = 8'haa,
  parameter [7:0]  CMD_D1  = 8'h55,
  parameter [7:0]  ENA_D2  = 8'ha0,
  parameter [7:0]  DIS_D2  = 8'h20
)
(
  // pins
  input  wire        sys_clk_i,
  input  wire [18:0] addr_lines_i,
  input  wire        chip_sel_n_i,
  input  wire        out_en_n_i,
  input  wire        wr_strobe_n_i,
  input  wire [7:0]  host_data_i,
  input  wire        host_oe_n_i,
  input  wire [15:0] prog_len_i,
  // resolved data wire
  output logic [7:0] bus_o
);
  logic [7:0]  mem [int];
  logic [18:0] qa [$];
  logic [7:0]  qd [$];
  logic [7:0]  wd, last_d, prev_d, rdv;
  logic [18:0] wa;
  logic        wr_q, rd_q, tog, lock;
  int          blc, prog, pon, wlen;
  wire wr_on = !chip_sel_n_i && !wr_strobe_n_i && out_en_n_i;
  wire rd_on = !chip_sel_n_i && !out_en_n_i && wr_strobe_n_i;
  initial {wr_q, rd_q, tog, lock, blc, prog, pon, wlen, last_d, prev_d} = '0;
  // ===========================================================
  // programming: command bytes are never stored
  task automatic commit();
    int s;
    bit cmd;
    s = 0;
    cmd = qa.size() >= 3 && qa[0] == CMD_A0 && qd[0] == CMD_D0 && qa[1] == CMD_A1 && qd[1] == CMD_D1
      && qa[2] == CMD_A2 && (qd[2] == ENA_D2 || qd[2] == DIS_D2);
    if (cmd)
    begin
      lock = (qd[2] == ENA_D2);
      s = 3;
    end
    if (cmd || !lock)
      for (int i = s; i < qa.size(); i++) mem[qa[i]] = qd[i];
    qa.delete();
    qd.delete();
  endtask
  always @*
    if (!host_oe_n_i) bus_o = host_data_i;
    else if (rd_on && prog > 0) bus_o = {~last_d[7], tog, last_d[5:0]};
    else if (rd_on) bus_o = rdv;
    else bus_o = ~prev_d;
  always @(negedge sys_clk_i)
  begin
    if (pon < PON_CYC) pon <= pon + 1;
    rdv <= mem.exists(addr_lines_i) ? mem[addr_lines_i] : 8'hff;
    if (!host_oe_n_i || rd_on) prev_d <= bus_o;
    rd_q <= rd_on;
    if (rd_on && !rd_q && prog > 0) tog <= !tog;
    wr_q <= wr_on;
    if (wr_on && !wr_q) wa <= addr_lines_i;
    if (wr_on) wd <= bus_o;
    wlen <= wr_on ? wlen + 1 : 0;
    if (!wr_on && wr_q && wlen > 1 && pon >= PON_CYC && prog == 0)
    begin
      qa.push_back(wa);
      qd.push_back(wd);
      last_d <= wd;
      blc <= 0;
    end
    else if (qa.size() > 0 && prog == 0)
    begin
      blc <= blc + 1;
      if (blc >= BLC_CYC || rd_on) prog <= prog_len_i;
    end
    else if (prog > 0)
    begin
      prog <= prog - 1;
      if (prog == 1) commit();
    end
  end
endmodule

// [sim/test_eepw_host.sv]
// self-checking bench for the page-write memory host controller
`timescale 1ns/100ps
module test_eepw_host;
  typedef struct packed {logic [1:0] op; logic [18:0] a; logic [7:0] d; logic lst, lk, md; logic [7:0] x;} eepw_row_t;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0;
  logic        cmd_last_i = 1'b0, use_lock_i = 1'b0, det_mode_i = 1'b0;
  logic [1:0]  cmd_op_i = 2'h0;
  logic [18:0] cmd_addr_i = 19'h0;
  logic [7:0]  cmd_wdata_i = 8'h0;
  logic [15:0] prog_len = 16'h003c;
  wire         cmd_ready_o, rsp_valid_o, busy_o, timeout_o, cs_n, oe_n, we_n, doe_n;
  wire [7:0]   rsp_rdata_o, dout, bus;
  wire [18:0]  addr;
  int          n_errors = 0, num_checks = 0;
  eepw_row_t   rows [17] = '{
    '{2'h1, 19'h00100, 8'h3c, 1'b1, 1'b0, 1'b0, 8'h00}, '{2'h0, 19'h00100, 8'h00, 1'b0, 1'b0, 1'b0, 8'h3c},
    '{2'h1, 19'h00205, 8'ha1, 1'b0, 1'b0, 1'b1, 8'h00}, '{2'h1, 19'h00203, 8'hb2, 1'b0, 1'b0, 1'b1, 8'h00},
    '{2'h1, 19'h00205, 8'hc3, 1'b1, 1'b0, 1'b1, 8'h00}, '{2'h0, 19'h00205, 8'h00, 1'b0, 1'b0, 1'b0, 8'hc3},
    '{2'h0, 19'h00203, 8'h00, 1'b0, 1'b0, 1'b0, 8'hb2}, '{2'h0, 19'h00204, 8'h00, 1'b0, 1'b0, 1'b0, 8'hff},
    '{2'h2, 19'h00000, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00}, '{2'h1, 19'h00300, 8'h11, 1'b1, 1'b0, 1'b0, 8'h01},
    '{2'h0, 19'h00300, 8'h00, 1'b0, 1'b0, 1'b0, 8'hff}, '{2'h1, 19'h00301, 8'h22, 1'b1, 1'b1, 1'b1, 8'h00},
    '{2'h0, 19'h00301, 8'h00, 1'b0, 1'b0, 1'b0, 8'h22}, '{2'h3, 19'h00000, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00},
    '{2'h1, 19'h00302, 8'h33, 1'b1, 1'b0, 1'b0, 8'h00}, '{2'h0, 19'h00302, 8'h00, 1'b0, 1'b0, 1'b0, 8'h33},
    '{2'h0, 19'h05555, 8'h00, 1'b0, 1'b0, 1'b0, 8'hff}};
  always #5 sys_clk_i = ~sys_clk_i;
  eepw_host #(.PON_CYC(32'd20), .WC_CYC(32'd200), .BLC_CYC(32'd100)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_last_i(cmd_last_i), .use_lock_i(use_lock_i), .det_mode_i(det_mode_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o), .timeout_o(timeout_o),
    .addr_lines_o(addr), .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .wr_strobe_n_o(we_n), .data_pins_o(dout),
    .data_pins_oe_n_o(doe_n), .data_pins_i(bus));
  eepw_dev_model dev (.sys_clk_i(sys_clk_i), .addr_lines_i(addr), .chip_sel_n_i(cs_n), .out_en_n_i(oe_n),
    .wr_strobe_n_i(we_n), .host_data_i(dout), .host_oe_n_i(doe_n), .prog_len_i(prog_len), .bus_o(bus));
  // ===========================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one command; reads compare data, finished writes compare the timeout flag
  task automatic run(input eepw_row_t r);
    int n;
    n = 0;
    cmd_valid_i <= 1'b1;
    cmd_op_i <= r.op;
    cmd_addr_i <= r.a;
    cmd_wdata_i <= r.d;
    cmd_last_i <= r.lst;
    use_lock_i <= r.lk;
    det_mode_i <= r.md;
    @(posedge sys_clk_i);
    while (cmd_ready_o !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 3000)
    begin
      n_errors++;
      $display("MISMATCH t=%0t ready wait got=%h exp=%h", $time, cmd_ready_o, 1'b1);
    end
    cmd_valid_i <= 1'b0;
    @(posedge sys_clk_i);
    if (r.op == 2'h1 && !r.lst) return;
    n = 0;
    while ((r.op == 2'h0 ? rsp_valid_o : !busy_o) !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 3000)
    begin
      n_errors++;
      $display("MISMATCH t=%0t answer wait got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    chk(r.op == 2'h0 ? rsp_rdata_o : {7'h0, timeout_o}, r.x);
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    chk({cs_n, oe_n, we_n, busy_o, cmd_ready_o}, 8'h1e);
    rst_i <= 1'b0;
    foreach (rows[i]) run(rows[i]);
    $display("table rows done");
    prog_len <= 16'd300;
    run('{2'h1, 19'h00400, 8'h5a, 1'b1, 1'b0, 1'b0, 8'h01});
    repeat (200) @(posedge sys_clk_i);
    prog_len <= 16'h003c;
    run('{2'h0, 19'h00400, 8'h00, 1'b0, 1'b0, 1'b0, 8'h5a});
    $display("slow programming done");
    run('{2'h1, 19'h00401, 8'h44, 1'b1, 1'b0, 1'b0, 8'h00});
    run('{2'h1, 19'h00500, 8'h77, 1'b0, 1'b0, 1'b0, 8'h00});
    for (int n = 0; n < 400 && timeout_o !== 1'b1; n++) @(posedge sys_clk_i);
    chk({7'h0, timeout_o}, 8'h01);
    repeat (200) @(posedge sys_clk_i);
    run('{2'h0, 19'h00500, 8'h00, 1'b0, 1'b0, 1'b0, 8'h77});
    $display("load window done");
    run('{2'h2, 19'h00000, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00});
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk({cs_n, oe_n, we_n, busy_o, cmd_ready_o}, 8'h1e);
    rst_i <= 1'b0;
    run('{2'h1, 19'h00600, 8'h66, 1'b1, 1'b0, 1'b0, 8'h01});
    run('{2'h0, 19'h00600, 8'h00, 1'b0, 1'b0, 1'b0, 8'hff});
    run('{2'h3, 19'h00000, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00});
    $display("reset with lock done");
    end_sim();
  end
endmodule
